// [bbcc_pkg.sv]
package bbcc_pkg;

  // System clock rate in hertz.
  localparam int unsigned CLK_HZ        = 25_000_000;
  // Crystal time base rate in hertz; one second is this many crystal rising edges.
  localparam int unsigned OSC_HZ        = 32_768;
  localparam int unsigned OSC_CNT_W     = 15;
  localparam logic [14:0] OSC_LAST      = 15'(OSC_HZ - 1);

  // Calibration period in hours and its length in seconds.
  localparam int unsigned CAL_PERIOD_H  = 72;
  localparam logic [18:0] CAL_PERIOD_S  = 19'(CAL_PERIOD_H * 3600);

  // Longest battery absence while unpowered that contents survive, in seconds.
  localparam int unsigned LOSS_TIME_S   = 15;
  // The same absence as clock cycles of the system clock.
  localparam int unsigned LOSS_CYCLES   = LOSS_TIME_S * CLK_HZ;
  localparam int unsigned LOSS_CNT_W    = 29;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_YEAR       = 8'h00;
  localparam logic [7:0] OFS_MONTH      = 8'h04;
  localparam logic [7:0] OFS_DAY        = 8'h08;
  localparam logic [7:0] OFS_WEEKDAY    = 8'h0C;
  localparam logic [7:0] OFS_HOUR       = 8'h10;
  localparam logic [7:0] OFS_MINUTE     = 8'h14;
  localparam logic [7:0] OFS_SECOND     = 8'h18;
  localparam logic [7:0] OFS_CALIB      = 8'h1C;
  localparam logic [7:0] OFS_FAULT      = 8'h20;
  localparam logic [7:0] OFS_IRQ_STS    = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h28;

  // Values after reset.
  localparam logic [15:0] RST_YEAR      = 16'h07D0;
  localparam logic [15:0] RST_MONTH     = 16'h0001;
  localparam logic [15:0] RST_DAY       = 16'h0001;
  localparam logic [15:0] RST_WEEKDAY   = 16'h0006;
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  localparam logic [7:0]  RST_CALIB     = 8'h00;

  // Field positions in the fault register.
  localparam int unsigned FLT_FAULT_BIT = 0;
  localparam int unsigned FLT_LOST_BIT  = 1;
  localparam int unsigned FLT_RELOAD_BIT = 2;
  // Field positions in the interrupt status and mask registers.
  localparam int unsigned IRQ_SEC_BIT   = 0;
  localparam int unsigned IRQ_FAULT_BIT = 1;
  localparam int unsigned IRQ_W         = 2;

  // Bus transfer type that starts a single transfer.
  localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;

  // Gregorian leap year test.
  function automatic logic bbcc_is_leap(input logic [15:0] year);
    return ((year % 16'h0004) == 16'h0000 && (year % 16'h0064) != 16'h0000)
        || ((year % 16'h0190) == 16'h0000);
  endfunction

  // Number of days in a month of a given year.
  function automatic logic [15:0] bbcc_month_days(input logic [15:0] month,
                                                  input logic [15:0] year);
    logic [15:0] days;
    days = 16'h001F;
    if (month == 16'h0004 || month == 16'h0006 || month == 16'h0009 || month == 16'h000B) begin
      days = 16'h001E;
    end else if (month == 16'h0002) begin
      days = bbcc_is_leap(year) ? 16'h001D : 16'h001C;
    end
    return days;
  endfunction

endpackage

// [bbcc_tick.sv]
// Divides the crystal time base down to one pulse per second.
module bbcc_tick
  import bbcc_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic srst_in,
  input  wire logic osc_in,
  input  wire logic run_in,
  output logic      sec_out
);

  logic                 osc_prev_q;  // Crystal level one cycle ago.
  logic [OSC_CNT_W-1:0] edge_cnt_q;  // Crystal rising edges this second.

  // Counts crystal rising edges and pulses once per full second.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      osc_prev_q <= 1'b0;
      edge_cnt_q <= '0;
      sec_out    <= 1'b0;
    end else begin
      osc_prev_q <= osc_in;
      sec_out    <= 1'b0;
      // The oscillator only runs while some supply is present.
      if (run_in && osc_in && !osc_prev_q) begin
        if (edge_cnt_q == OSC_LAST) begin
          edge_cnt_q <= '0;
          sec_out    <= 1'b1;
        end else begin
          edge_cnt_q <= edge_cnt_q + 1'b1;
        end
      end
    end
  end

endmodule // bbcc_tick

// [bbcc_cal.sv]
// Spreads a signed number of corrective seconds evenly over each period.
module bbcc_cal
  import bbcc_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       srst_in,
  input  wire logic       sec_in,
  input  wire logic [7:0] cal_in,
  output logic            add_out,
  output logic            skip_out
);

  logic [18:0] acc_q;  // Fractional correction gathered so far.
  logic [18:0] mag;    // Magnitude of the signed calibration value.
  logic [18:0] acc_n;  // Accumulator after this second.

  // A positive value adds seconds; a negative one raises skip_out, which removes none.
  always_comb begin
    mag   = cal_in[7] ? 19'(8'(-cal_in)) : 19'(cal_in);
    acc_n = acc_q + mag;
  end

  // Every second adds the magnitude; crossing the period yields one correction.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      acc_q    <= '0;
      add_out  <= 1'b0;
      skip_out <= 1'b0;
    end else begin
      add_out  <= 1'b0;
      skip_out <= 1'b0;
      if (sec_in) begin
        if (acc_n >= CAL_PERIOD_S) begin
          acc_q    <= acc_n - CAL_PERIOD_S;
          add_out  <= !cal_in[7];
          skip_out <= cal_in[7];
        end else begin
          acc_q <= acc_n;
        end
      end
    end
  end

endmodule // bbcc_cal

// [bbcc_top.sv]
// How it works
// - Keep date and time; run on battery.
// - Battery gone over 15 s unpowered: fault.
// - Seven readable, writable count registers.
// - Year holds the full four-digit value.
// - Weekday counts 1 to 7, then wraps.
// - Corruption sets a readable fault flag.
// - Second base comes from 32.768 kHz crystal.
// - Signed calibration spreads seconds over 72 h; negative values remove none here.
// - Hours count in 24-hour form.
// - Reload then power cycle clears fault.
//
// Local design decisions: the address map and the AHB-Lite register port.
module bbcc_top
  import bbcc_pkg::*;
#(
  parameter int unsigned LOSS_LIMIT = LOSS_CYCLES  // Unpowered battery-free cycles tolerated.
) (
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        osc_in,
  input  wire logic        main_power_in,
  input  wire logic        battery_ok_in,
  input  wire logic        corrupt_in,
  input  wire logic        damage_in,
  output logic             fault_led_out,
  output logic             irq_out
);

  logic [15:0]           year_q;       // Full calendar year.
  logic [15:0]           month_q;      // Month, 1 to 12.
  logic [15:0]           day_q;        // Day of month.
  logic [15:0]           weekday_q;    // Day of week, Monday is 1.
  logic [15:0]           hour_q;       // Hour, 0 to 23.
  logic [15:0]           minute_q;     // Minute, 0 to 59.
  logic [15:0]           second_q;     // Second, 0 to 59.
  logic [7:0]            calib_q;      // Signed calibration value.
  logic [IRQ_W-1:0]      irq_sts_q;    // Sticky interrupt events.
  logic [IRQ_W-1:0]      irq_mask_q;   // Interrupt enables.
  logic [IRQ_W-1:0]      irq_sts_d;    // Next interrupt events.
  logic                  fault_q;      // Clock fault flag.
  logic                  lost_q;       // Contents lost while unpowered.
  logic                  reload_q;     // Time was set since the fault.
  logic                  power_prev_q; // Main power one cycle ago.
  logic [LOSS_CNT_W-1:0] loss_cnt_q;   // Unpowered, battery-free cycles.
  logic                  wr_q;         // A write is in its data phase.
  logic [7:0]            wr_ofs_q;     // Offset of that write.
  logic                  extra_q;      // Second advance owed by calibration.
  logic                  sec_tick;     // One crystal second elapsed.
  logic                  cal_add;      // Calibration adds a second.
  logic                  cal_skip;     // Calibration skip, which drops no second.
  logic                  advance;      // Step the count by one second.
  logic                  power_up;     // Main power has just returned.
  logic                  fault_set;    // An event raises the fault.
  logic [15:0]           wdata;        // Low half of the write data.
  logic [15:0]           n_year;       // Values after one second.
  logic [15:0]           n_month;
  logic [15:0]           n_day;
  logic [15:0]           n_weekday;
  logic [15:0]           n_hour;
  logic [15:0]           n_minute;
  logic [15:0]           n_second;

  // Assembles the word that a read at a given offset returns.
  function automatic logic [31:0] read_word(input logic [7:0] ofs);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (ofs)
      OFS_YEAR:     w = {16'h0000, year_q};
      OFS_MONTH:    w = {16'h0000, month_q};
      OFS_DAY:      w = {16'h0000, day_q};
      OFS_WEEKDAY:  w = {16'h0000, weekday_q};
      OFS_HOUR:     w = {16'h0000, hour_q};
      OFS_MINUTE:   w = {16'h0000, minute_q};
      OFS_SECOND:   w = {16'h0000, second_q};
      OFS_CALIB:    w = {24'h00_0000, calib_q};
      OFS_FAULT:    w = {29'h0000_0000, reload_q, lost_q, fault_q};
      OFS_IRQ_STS:  w = {30'h0000_0000, irq_sts_q};
      OFS_IRQ_MASK: w = {30'h0000_0000, irq_mask_q};
      default:      w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Crystal divider; it stops when neither main power nor battery is present.
  bbcc_tick u_tick (
    .clock_in (clock_in),
    .srst_in  (srst_in),
    .osc_in   (osc_in),
    .run_in   (main_power_in || battery_ok_in),
    .sec_out  (sec_tick)
  );

  // Drift trim over the calibration period; only added seconds are applied.
  bbcc_cal u_cal (
    .clock_in (clock_in),
    .srst_in  (srst_in),
    .sec_in   (sec_tick),
    .cal_in   (calib_q),
    .add_out  (cal_add),
    .skip_out (cal_skip)
  );

  // A skip comes a cycle after its tick, so it swallows nothing; an added second comes two cycles after its tick.
  assign advance  = extra_q || (sec_tick && !cal_skip);
  assign power_up = main_power_in && !power_prev_q;
  assign wdata    = hwdata_in[15:0];

  // Bus address phase: take reads at once and hold writes for the data phase.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wr_q          <= 1'b0;
      wr_ofs_q      <= 8'h00;
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_q          <= 1'b0;
      if (hsel_in && hready_in && htrans_in == HTRANS_NONSEQ) begin
        // Only the low byte of the address selects the register.
        wr_q     <= hwrite_in;
        wr_ofs_q <= haddr_in[7:0];
        if (!hwrite_in) begin
          hrdata_out <= read_word(haddr_in[7:0]);
        end
      end
    end
  end

  // Next calendar values one second on, with correct month lengths.
  always_comb begin
    n_year    = year_q;
    n_month   = month_q;
    n_day     = day_q;
    n_weekday = weekday_q;
    n_hour    = hour_q;
    n_minute  = minute_q;
    n_second  = second_q + 16'h0001;
    if (second_q >= 16'h003B) begin
      n_second = 16'h0000;
      n_minute = minute_q + 16'h0001;
      if (minute_q >= 16'h003B) begin
        n_minute = 16'h0000;
        n_hour   = hour_q + 16'h0001;
        if (hour_q >= 16'h0017) begin
          // Midnight in 24-hour form starts a new day.
          n_hour    = 16'h0000;
          n_day     = day_q + 16'h0001;
          n_weekday = (weekday_q >= 16'h0007) ? 16'h0001 : weekday_q + 16'h0001;
          if (day_q >= bbcc_month_days(month_q, year_q)) begin
            n_day   = 16'h0001;
            n_month = month_q + 16'h0001;
            if (month_q >= 16'h000C) begin
              n_month = 16'h0001;
              n_year  = year_q + 16'h0001;
            end
          end
        end
      end
    end
  end

  // The running count; a write loads its field over any advance.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      year_q    <= RST_YEAR;
      month_q   <= RST_MONTH;
      day_q     <= RST_DAY;
      weekday_q <= RST_WEEKDAY;
      hour_q    <= RST_ZERO;
      minute_q  <= RST_ZERO;
      second_q  <= RST_ZERO;
    end else begin
      if (advance) begin
        year_q    <= n_year;
        month_q   <= n_month;
        day_q     <= n_day;
        weekday_q <= n_weekday;
        hour_q    <= n_hour;
        minute_q  <= n_minute;
        second_q  <= n_second;
      end
      if (wr_q) begin
        // Other fields keep counting while one is being written.
        unique case (wr_ofs_q)
          OFS_YEAR:    year_q    <= wdata;
          OFS_MONTH:   month_q   <= wdata;
          OFS_DAY:     day_q     <= wdata;
          OFS_WEEKDAY: weekday_q <= wdata;
          OFS_HOUR:    hour_q    <= wdata;
          OFS_MINUTE:  minute_q  <= wdata;
          OFS_SECOND:  second_q  <= wdata;
          default:     ;
        endcase
      end
    end
  end

  // Calibration value and interrupt mask written by software.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      calib_q    <= RST_CALIB;
      irq_mask_q <= '0;
    end else if (wr_q) begin
      if (wr_ofs_q == OFS_CALIB) begin
        calib_q <= hwdata_in[7:0];
      end
      if (wr_ofs_q == OFS_IRQ_MASK) begin
        irq_mask_q <= hwdata_in[IRQ_W-1:0];
      end
    end
  end

  // Calibration owes one extra advance the cycle after an added second.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      extra_q <= 1'b0;
    end else begin
      extra_q <= cal_add;
    end
  end

  // Times how long the device sits with neither main power nor battery.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      loss_cnt_q   <= '0;
      lost_q       <= 1'b0;
      power_prev_q <= 1'b1; // Reset is not taken as a power-up.
    end else begin
      power_prev_q <= main_power_in;
      if (main_power_in || battery_ok_in) begin
        loss_cnt_q <= '0;
      end else if (loss_cnt_q < LOSS_CNT_W'(LOSS_LIMIT)) begin
        loss_cnt_q <= loss_cnt_q + 1'b1;
      end else begin
        lost_q <= 1'b1;
      end
      // Loss is reported at power-up, which consumes it.
      if (power_up && lost_q) begin
        lost_q <= 1'b0;
      end
    end
  end

  // A fault arises from lost contents at power-up, corruption or damage.
  assign fault_set = (power_up && lost_q) || corrupt_in || damage_in;

  // Fault flag, the record of a fresh setting, and the fault indicator.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      fault_q       <= 1'b0;
      reload_q      <= 1'b0;
      fault_led_out <= 1'b0;
    end else begin
      if (wr_q && wr_ofs_q <= OFS_SECOND) begin
        reload_q <= 1'b1;
      end
      // A power cycle after a fresh setting clears a fault without damage.
      if (power_up && fault_q && reload_q && !damage_in) begin
        fault_q  <= 1'b0;
        reload_q <= 1'b0;
      end
      // A new fault wins over the clear and forgets any earlier setting.
      if (fault_set) begin
        fault_q  <= 1'b1;
        reload_q <= 1'b0;
      end
      fault_led_out <= fault_set || (fault_q && !(power_up && reload_q && !damage_in));
    end
  end

  // Sticky events; a one written clears its bit unless the event recurs.
  always_comb begin
    irq_sts_d = irq_sts_q;
    if (wr_q && wr_ofs_q == OFS_IRQ_STS) begin
      irq_sts_d = irq_sts_q & ~hwdata_in[IRQ_W-1:0];
    end
    if (advance) begin
      irq_sts_d[IRQ_SEC_BIT] = 1'b1;
    end
    if (fault_set && !fault_q) begin
      irq_sts_d[IRQ_FAULT_BIT] = 1'b1;
    end
  end

  // Interrupt status and the level output gated by the mask.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      irq_sts_q <= '0;
      irq_out   <= 1'b0;
    end else begin
      irq_sts_q <= irq_sts_d;
      irq_out   <= |(irq_sts_d & irq_mask_q);
    end
  end

  sec_wrap_a: assert property (
    @(posedge clock_in) disable iff (srst_in)
    advance && !wr_q && second_q == 16'h003B && minute_q < 16'h003B
    |=> second_q == 16'h0000 && minute_q == $past(minute_q) + 16'h0001)
    else $error("Second did not roll into the minute.");

  hour_wrap_a: assert property (
    @(posedge clock_in) disable iff (srst_in)
    advance && !wr_q && hour_q == 16'h0017 && minute_q == 16'h003B && second_q == 16'h003B
    |=> hour_q == 16'h0000)
    else $error("Hour did not wrap after 23.");

  weekday_wrap_a: assert property (
    @(posedge clock_in) disable iff (srst_in)
    advance && !wr_q && weekday_q == 16'h0007 && hour_q == 16'h0017
    && minute_q == 16'h003B && second_q == 16'h003B
    |=> weekday_q == 16'h0001)
    else $error("Weekday did not wrap from 7 to 1.");

  year_step_a: assert property (
    @(posedge clock_in) disable iff (srst_in)
    advance && !wr_q && month_q == 16'h000C && day_q == 16'h001F && hour_q == 16'h0017
    && minute_q == 16'h003B && second_q == 16'h003B
    |=> year_q == $past(year_q) + 16'h0001 && month_q == 16'h0001 && day_q == 16'h0001)
    else $error("Year did not advance at the end of December.");

  write_load_a: assert property (
    @(posedge clock_in) disable iff (srst_in)
    wr_q && wr_ofs_q == OFS_MINUTE |=> minute_q == $past(hwdata_in[15:0]))
    else $error("Written minute was not loaded.");

  loss_fault_a: assert property (
    @(posedge clock_in) disable iff (srst_in)
    power_up && lost_q |=> fault_q && fault_led_out && !lost_q)
    else $error("Lost contents did not raise the fault at power-up.");

  corrupt_fault_a: assert property (
    @(posedge clock_in) disable iff (srst_in)
    corrupt_in |=> fault_q && fault_led_out)
    else $error("Corruption did not raise the fault.");

  fault_clear_a: assert property (
    @(posedge clock_in) disable iff (srst_in)
    power_up && fault_q && reload_q && !lost_q && !corrupt_in && !damage_in
    |=> !fault_q && !fault_led_out)
    else $error("Fault did not clear after reload and power cycle.");

  cal_add_a: assert property (
    @(posedge clock_in) disable iff (srst_in)
    cal_add ##1 !wr_q |=> second_q != $past(second_q))
    else $error("Added calibration second was not applied.");

  no_supply_a: assert property (
    @(posedge clock_in) disable iff (srst_in)
    !main_power_in && !battery_ok_in ##1 !main_power_in && !battery_ok_in
    |=> !sec_tick)
    else $error("Clock advanced with no supply at all.");

  irq_level_a: assert property (
    @(posedge clock_in) disable iff (srst_in)
    |(irq_sts_q & irq_mask_q) && !(wr_q && wr_ofs_q == OFS_IRQ_STS) |=> irq_out)
    else $error("Unmasked event did not raise the interrupt.");

endmodule // bbcc_top

// [test_battery_backed_calendar_clock.sv]
// Self-checking bench for the calendar clock: bus, fault, interrupt and rollover.
module test_battery_backed_calendar_clock
  import bbcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock_in, srst_in, hsel_in, hwrite_in;   // Clock, reset and bus controls.
  logic [31:0] haddr_in, hwdata_in;                     // Bus address and write data.
  logic [1:0]  htrans_in;                               // Bus transfer type.
  logic [2:0]  hsize_in;                                // Bus transfer size.
  logic        osc_in, main_power_in, battery_ok_in;    // Time base and supplies.
  logic        corrupt_in, damage_in;                   // Fault sources.
  logic [31:0] hrdata_out;                              // Bus read data.
  logic        hreadyout_out, hresp_out;                // Bus status.
  logic        fault_led_out, irq_out;                  // Indicator and interrupt.
  int          err_total, n_checks;                     // Mismatch and comparison counts.
  integer      seed = 32'h0000_c363;                    // Fixed random seed.
  int          mv[7];                                   // Model of the seven counts.
  logic [31:0] rd, v;                                   // Scratch bus values.
  logic [7:0]  ofs[7] = '{OFS_YEAR, OFS_MONTH, OFS_DAY, OFS_WEEKDAY, OFS_HOUR, OFS_MINUTE,
                          OFS_SECOND};                  // Count register offsets.
  logic [15:0] rstv[7] = '{RST_YEAR, RST_MONTH, RST_DAY, RST_WEEKDAY, RST_ZERO, RST_ZERO,
                           RST_ZERO};                   // Count values after reset.

  // A short loss limit keeps the power tests brief.
  bbcc_top #(.LOSS_LIMIT(20)) uut (
    .clock_in(clock_in), .srst_in(srst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .osc_in(osc_in),
    .main_power_in(main_power_in), .battery_ok_in(battery_ok_in), .corrupt_in(corrupt_in),
    .damage_in(damage_in), .fault_led_out(fault_led_out), .irq_out(irq_out));

  // The system clock toggles every half period of 20 ns.
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compares one seen value with its expectation.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits for a rising edge with ready high; a hang ends the run.
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clock_in);
      if (hreadyout_out === 1'b1) break;
    end
    if (i == 50) begin
      err_total++;
      final_report();
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel_in   <= 1'b1;
    haddr_in  <= {24'h00_0000, a};
    htrans_in <= HTRANS_NONSEQ;
    hwrite_in <= wr;
    wait_rdy();
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    wait_rdy();
    r = hrdata_out;
    check("bus response", {31'h0000_0000, hresp_out}, 32'h0000_0000);
  endtask

  // Writes one register.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, rd);
  endtask

  // Reads one register and compares it.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(a, 1'b0, 32'h0000_0000, rd);
    check(what, rd, exp);
  endtask

  // Lets a number of clock edges pass.
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // Checks the fault flag in the register and at the indicator.
  task automatic fchk(input logic exp);
    bus(OFS_FAULT, 1'b0, 32'h0000_0000, rd);
    check("fault flag", {31'h0000_0000, rd[FLT_FAULT_BIT]}, {31'h0000_0000, exp});
    check("fault led", {31'h0000_0000, fault_led_out}, {31'h0000_0000, exp});
  endtask

  // Reloads a count and cycles main power with the battery present.
  task automatic reload_cycle();
    wr_reg(OFS_SECOND, 32'h0000_0000);
    main_power_in <= 1'b0;
    tick(5);
    main_power_in <= 1'b1;
    tick(3);
  endtask

  // Days in a month, leap years included.
  function automatic int mdays(input int m, input int y);
    if (m == 2) return ((y % 4 == 0 && y % 100 != 0) || y % 400 == 0) ? 29 : 28;
    if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
    return 31;
  endfunction

  // Advances the model by one second with all carries.
  task automatic adv();
    mv[6] = mv[6] + 1;
    if (mv[6] == 60) begin
      mv[6] = 0;
      mv[5]++;
    end
    if (mv[5] == 60) begin
      mv[5] = 0;
      mv[4]++;
    end
    if (mv[4] == 24) begin
      mv[4] = 0;
      mv[3] = mv[3] % 7 + 1;
      mv[2]++;
    end
    if (mv[2] > mdays(mv[1], mv[0])) begin
      mv[2] = 1;
      mv[1]++;
    end
    if (mv[1] == 13) begin
      mv[1] = 1;
      mv[0]++;
    end
  endtask

  // Main sequence of tests.
  initial begin
    err_total = 0;
    n_checks = 0;
    srst_in = 1'b1;
    hsel_in = 1'b0;
    hwrite_in = 1'b0;
    haddr_in = 32'h0000_0000;
    hwdata_in = 32'h0000_0000;
    htrans_in = 2'h0;
    hsize_in = 3'h2;
    osc_in = 1'b0;
    main_power_in = 1'b1;
    battery_ok_in = 1'b1;
    corrupt_in = 1'b0;
    damage_in = 1'b0;
    tick(6);
    srst_in <= 1'b0;
    tick(1);
    // Values after reset.
    for (int i = 0; i < 7; i++) rd_chk(ofs[i], {16'h0000, rstv[i]}, "reset count");
    rd_chk(OFS_CALIB, 32'h0000_0000, "reset calib");
    rd_chk(OFS_IRQ_MASK, 32'h0000_0000, "reset mask");
    fchk(1'b0);
    $display("test reset done");
    // Random values written into each count read back in the low half.
    for (int i = 0; i < 7; i++) begin
      v = $random(seed);
      wr_reg(ofs[i], v);
      rd_chk(ofs[i], {16'h0000, v[15:0]}, "count rw");
    end
    v = $random(seed);
    wr_reg(OFS_CALIB, v);
    rd_chk(OFS_CALIB, {24'h00_0000, v[7:0]}, "calib rw");
    wr_reg(8'h40, v);
    rd_chk(8'h40, 32'h0000_0000, "unmapped");
    $display("test rw done");
    // A short absence survives; a long one raises the fault on power-up.
    wr_reg(OFS_IRQ_MASK, 32'h0000_0002);
    main_power_in <= 1'b0;
    battery_ok_in <= 1'b0;
    tick(10);
    battery_ok_in <= 1'b1;
    tick(30);
    main_power_in <= 1'b1;
    tick(3);
    fchk(1'b0);
    main_power_in <= 1'b0;
    battery_ok_in <= 1'b0;
    tick(30);
    main_power_in <= 1'b1;
    battery_ok_in <= 1'b1;
    tick(3);
    fchk(1'b1);
    check("irq raised", {31'h0000_0000, irq_out}, 32'h0000_0001);
    rd_chk(OFS_IRQ_STS, 32'h0000_0002, "irq status");
    wr_reg(OFS_IRQ_STS, 32'h0000_0002);
    tick(2);
    check("irq cleared", {31'h0000_0000, irq_out}, 32'h0000_0000);
    reload_cycle();
    fchk(1'b0);
    // Corruption sets the flag; damage keeps it through a reload.
    corrupt_in <= 1'b1;
    tick(1);
    corrupt_in <= 1'b0;
    tick(2);
    fchk(1'b1);
    reload_cycle();
    fchk(1'b0);
    damage_in <= 1'b1;
    tick(2);
    reload_cycle();
    fchk(1'b1);
    damage_in <= 1'b0;
    reload_cycle();
    fchk(1'b0);
    $display("test fault done");
    // Last second of a year, completed on battery alone.
    wr_reg(OFS_IRQ_MASK, 32'h0000_0003);
    wr_reg(OFS_IRQ_STS, 32'h0000_0003);
    mv = '{2003, 12, 31, 7, 23, 59, 59};
    for (int i = 0; i < 7; i++) wr_reg(ofs[i], 32'(mv[i]));
    repeat (65533) begin
      @(posedge clock_in);
      osc_in <= ~osc_in;
    end
    tick(5);
    rd_chk(OFS_SECOND, 32'h0000_003B, "one edge short");
    main_power_in <= 1'b0;
    repeat (2) begin
      @(posedge clock_in);
      osc_in <= ~osc_in;
    end
    tick(5);
    main_power_in <= 1'b1;
    tick(3);
    adv();
    for (int i = 0; i < 7; i++) rd_chk(ofs[i], 32'(mv[i]), "rolled count");
    check("irq second", {31'h0000_0000, irq_out}, 32'h0000_0001);
    rd_chk(OFS_IRQ_STS, 32'h0000_0001, "second status");
    fchk(1'b0);
    $display("test rollover done");
    final_report();
  end
endmodule // test_battery_backed_calendar_clock
